// file: hw/pcd_params.svh
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH

// Clock period, in picoseconds
`define PCD_CLK_PERIOD_PS 8000
// Level width and settings
`define PCD_LEVEL_W 5
`define PCD_LEVEL_FULL 5'h1F
`define PCD_LEVEL_OFF 5'h00
// Shutdown low time, in microseconds (1.5 ms)
`define PCD_OFF_TIME_US 1500
`define PCD_OFF_CYCLES ((`PCD_OFF_TIME_US * 1000000) / `PCD_CLK_PERIOD_PS)
// Least pulse spacing, in nanoseconds
`define PCD_SPACE_TIME_NS 300
`define PCD_SPACE_CYCLES (((`PCD_SPACE_TIME_NS * 1000) + `PCD_CLK_PERIOD_PS - 1) / `PCD_CLK_PERIOD_PS)
// Shortest pulse period at the top rate of 1 MHz, in nanoseconds
`define PCD_PERIOD_TIME_NS 1000
`define PCD_PERIOD_CYCLES (((`PCD_PERIOD_TIME_NS * 1000) + `PCD_CLK_PERIOD_PS - 1) / `PCD_CLK_PERIOD_PS)
// Single-wire pulse low time cap, in microseconds (0.25 ms, host keeps below)
`define PCD_SW_LOW_TIME_US 250
`define PCD_SW_LOW_CYCLES ((`PCD_SW_LOW_TIME_US * 1000000) / `PCD_CLK_PERIOD_PS)
// Setup wait after enable before first pulse, in microseconds
`define PCD_SETUP_TIME_US 10
`define PCD_SETUP_CYCLES (((`PCD_SETUP_TIME_US * 1000000) + `PCD_CLK_PERIOD_PS - 1) / `PCD_CLK_PERIOD_PS)

`endif

// file: hw/pcd_pkg.sv
package pcd_pkg;
	typedef logic [4:0] pcd_level_type;
	typedef enum logic [1:0] {PCD_SHUT, PCD_ON, PCD_HOT} pcd_mode_type;
	typedef enum logic [2:0] {PCH_IDLE, PCH_ENABLE, PCH_WAIT, PCH_LOW, PCH_HIGH, PCH_OFF} pcd_host_state_type;
	typedef logic [1:0] pcd_group_type;
endpackage

// file: hw/pcd_link_if.sv
`timescale 1ns/1ps
interface pcd_link_if;
	logic chip_on;
	logic main_group_pulse_n;
	logic sub_group_pulse_n;
	modport device (input chip_on, input main_group_pulse_n, input sub_group_pulse_n);
	modport host (output chip_on, output main_group_pulse_n, output sub_group_pulse_n);
endinterface

// file: hw/pcd_device.sv
`timescale 1ns/1ps
`include "pcd_params.svh"
// Functional notes
// - Two identical independent group dimming machines
// - Host raises chip_on before any pulses
// - First falling edge sets full 31 mA
// - Each later falling edge lowers 1 mA
// - Thirty-second pulse turns group off
// - Next pulse after off returns full scale
// - Host spaces pulses at least 300 ns
// - Count every pulse from 5 kHz to 1 MHz
// - chip_on low 1.5 ms enters shutdown
// - Group edges ignored while chip_on low, except an edge that falls with chip_on
// - Over-temperature trip zeroes both channel outputs, enabled stays high
// - Resume after cooling past hysteresis
// - Single wire: rise enables, first pulse full
// - Single wire low pulses under 0.25 ms
// - Single wire held low ends in shutdown
// - Enabling from shutdown starts at zero current
module pcd_device #(
	parameter int OFF_CYCLES = `PCD_OFF_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Link from the host
	pcd_link_if.device link,
	// Thermal sensor flags
	input wire logic over_temp,
	input wire logic temp_cooled,
	// Channel current settings, enable and thermal status
	output pcd_pkg::pcd_level_type primary_led_channels,
	output pcd_pkg::pcd_level_type secondary_led_channels,
	output logic enabled,
	output logic thermal_off
);
	import pcd_pkg::*;

	typedef struct packed {
		logic [1:0] on_sync;
		logic on_prev;
		logic [1:0] main_sync;
		logic [1:0] sub_sync;
		logic [1:0] grp_prev;
		pcd_mode_type mode;
		logic shut;
		logic [31:0] low_cnt;
		pcd_level_type [1:0] level;
		pcd_level_type [1:0] out_level;
		logic en_out;
		logic hot_out;
	} pcd_dev_state_type;

	pcd_dev_state_type s_reg;
	pcd_dev_state_type s_next;
	logic [1:0] grp_now;
	logic [1:0] grp_fall;

	////////////////////////////////////////////////////////////////////////////
	// Edge detection reads only the second synchroniser stage
	assign grp_now = {s_reg.sub_sync[1], s_reg.main_sync[1]};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_edge
			assign grp_fall[g] = s_reg.grp_prev[g] & ~grp_now[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next = s_reg;
		s_next.on_sync = {s_reg.on_sync[0], link.chip_on};
		s_next.main_sync = {s_reg.main_sync[0], link.main_group_pulse_n};
		s_next.sub_sync = {s_reg.sub_sync[0], link.sub_group_pulse_n};
		s_next.grp_prev = grp_now;
		s_next.on_prev = s_reg.on_sync[1];
		// Shutdown timer: only a long low counts, short single-wire pulses do not
		if (s_reg.on_sync[1]) begin
			s_next.low_cnt = '0;
			if (s_reg.shut) begin
				s_next.shut = 1'b0;
			end
		end else if (s_reg.low_cnt >= 32'(OFF_CYCLES - 1)) begin
			s_next.shut = 1'b1;
		end else begin
			s_next.low_cnt = s_reg.low_cnt + 32'h0000_0001;
		end
		case (s_reg.mode)
			PCD_SHUT: begin
				if (!s_reg.shut && s_reg.on_sync[1]) begin
					s_next.mode = PCD_ON;
				end
			end
			PCD_ON: begin
				if (over_temp) begin
					s_next.mode = PCD_HOT;
				end
			end
			PCD_HOT: begin
				if (temp_cooled && !over_temp) begin
					s_next.mode = PCD_ON;
				end
			end
			default: s_next.mode = PCD_SHUT;
		endcase
		if (s_next.shut) begin
			s_next.mode = PCD_SHUT;
		end
		for (int i = 0; i < 2; i++) begin
			if (s_reg.shut) begin
				s_next.level[i] = `PCD_LEVEL_OFF;
			// A single-wire pulse drops enable together with the edge,
			// so enable seen one cycle before the edge still counts
			end else if (grp_fall[i] && (s_reg.on_sync[1] || s_reg.on_prev)) begin
				if (s_reg.level[i] == `PCD_LEVEL_OFF) begin
					s_next.level[i] = `PCD_LEVEL_FULL;
				end else begin
					s_next.level[i] = s_reg.level[i] - 5'h01;
				end
			end
			// Thermal trip blanks outputs but keeps the setting
			s_next.out_level[i] = (s_next.mode == PCD_ON) ? s_next.level[i] : `PCD_LEVEL_OFF;
		end
		s_next.en_out = (s_next.mode != PCD_SHUT);
		s_next.hot_out = (s_next.mode == PCD_HOT);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '{on_sync: 2'h0, main_sync: 2'h3, sub_sync: 2'h3, grp_prev: 2'h3,
				mode: PCD_SHUT, shut: 1'b1, on_prev: 1'b0, low_cnt: 32'h0000_0000,
				level: '0, out_level: '0, en_out: 1'b0, hot_out: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign primary_led_channels = s_reg.out_level[0];
	assign secondary_led_channels = s_reg.out_level[1];
	assign enabled = s_reg.en_out;
	assign thermal_off = s_reg.hot_out;
endmodule // pcd_device

// file: hw/pcd_host.sv
`timescale 1ns/1ps
`include "pcd_params.svh"
module pcd_host #(
	parameter int OFF_CYCLES = `PCD_OFF_CYCLES,
	parameter int SETUP_CYCLES = `PCD_SETUP_CYCLES,
	parameter int SPACE_CYCLES = `PCD_SPACE_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// User commands and busy status
	input wire logic cmd_enable,
	input wire logic cmd_shutdown,
	input wire pcd_pkg::pcd_group_type cmd_pulse,
	input wire logic single_wire,
	output logic busy,
	// Link to the device
	pcd_link_if.host link
);
	import pcd_pkg::*;

	typedef struct packed {
		pcd_host_state_type st;
		logic [31:0] cnt;
		pcd_group_type grp;
		logic on;
		logic [1:0] pn;
		logic busy;
	} pcd_host_reg_type;

	pcd_host_reg_type h_reg;
	pcd_host_reg_type h_next;

	// High time stretched so a pulse train never runs faster than 1 MHz
	localparam int HIGH_CYCLES = (`PCD_PERIOD_CYCLES - SPACE_CYCLES - 1 > SPACE_CYCLES) ?
		(`PCD_PERIOD_CYCLES - SPACE_CYCLES - 1) : SPACE_CYCLES;

	always_comb begin
		h_next = h_reg;
		h_next.cnt = h_reg.cnt + 32'h0000_0001;
		case (h_reg.st)
			PCH_IDLE: begin
				h_next.cnt = '0;
				if (cmd_shutdown) begin
					h_next.st = PCH_OFF;
					h_next.on = 1'b0;
					h_next.pn = 2'h3;
				end else if (cmd_enable && !h_reg.on) begin
					h_next.st = PCH_WAIT;
					h_next.on = 1'b1;
				end else if (cmd_pulse != 2'h0 && h_reg.on) begin
					h_next.st = PCH_LOW;
					h_next.grp = single_wire ? 2'h3 : cmd_pulse;
					h_next.pn = ~(single_wire ? 2'h3 : cmd_pulse);
					h_next.on = ~single_wire;
				end
			end
			PCH_WAIT: begin
				if (h_reg.cnt >= 32'(SETUP_CYCLES - 1)) begin
					h_next.st = PCH_IDLE;
				end
			end
			PCH_LOW: begin
				// Low time stays well under the single-wire cap
				if (h_reg.cnt >= 32'(SPACE_CYCLES - 1)) begin
					h_next.st = PCH_HIGH;
					h_next.cnt = '0;
					h_next.pn = 2'h3;
					h_next.on = 1'b1;
				end
			end
			PCH_HIGH: begin
				if (h_reg.cnt >= 32'(HIGH_CYCLES - 1)) begin
					h_next.st = PCH_IDLE;
				end
			end
			PCH_OFF: begin
				// Hold past the shutdown time with margin
				if (h_reg.cnt >= 32'(OFF_CYCLES + 15)) begin
					h_next.st = PCH_IDLE;
				end
			end
			default: h_next.st = PCH_IDLE;
		endcase
		h_next.busy = (h_next.st != PCH_IDLE);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			h_reg <= '{st: PCH_IDLE, cnt: 32'h0000_0000, grp: 2'h0, on: 1'b0,
				pn: 2'h3, busy: 1'b0};
		end else begin
			h_reg <= h_next;
		end
	end

	assign link.chip_on = h_reg.on;
	assign link.main_group_pulse_n = h_reg.pn[0];
	assign link.sub_group_pulse_n = h_reg.pn[1];
	assign busy = h_reg.busy;
endmodule // pcd_host

// file: tb/pcd_checker.sv
`timescale 1ns/1ps
module pcd_checker #(
	parameter int OFF_CYCLES = 200
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Link, thermal flag and device outputs
	input wire logic chip_on,
	input wire logic main_group_pulse_n,
	input wire logic sub_group_pulse_n,
	input wire logic over_temp,
	input wire pcd_pkg::pcd_level_type primary_led_channels,
	input wire pcd_pkg::pcd_level_type secondary_led_channels,
	input wire logic enabled,
	input wire logic thermal_off
);
	import pcd_pkg::*;
	int low_cnt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	function automatic pcd_level_type nxt(pcd_level_type v);
		return (v == 5'h00) ? 5'h1F : v - 5'h01;
	endfunction
	// Low time of the enable line, so shutdown can be given a deadline
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			low_cnt <= 0;
		else
			low_cnt <= chip_on ? 0 : low_cnt + 1;
	end
	////////////////////////////////////////
	AST_MAIN_STEP: assert property (
		$fell(main_group_pulse_n) && $past(chip_on) && enabled && !thermal_off
		|-> ##4 primary_led_channels == nxt($past(primary_led_channels, 4)))
		else $error("main level step wrong");
	AST_SUB_STEP: assert property (
		$fell(sub_group_pulse_n) && $past(chip_on) && enabled && !thermal_off
		|-> ##4 secondary_led_channels == nxt($past(secondary_led_channels, 4)))
		else $error("sub level step wrong");
	AST_PULSE_LOW: assert property (
		$fell(main_group_pulse_n) |-> !main_group_pulse_n [*8])
		else $error("pulse low too short");
	AST_ON_FIRST: assert property (
		$fell(sub_group_pulse_n) |-> $past(chip_on))
		else $error("pulse before enable");
	AST_SHUT_ZERO: assert property (
		!enabled |-> primary_led_channels == 5'h00 && secondary_led_channels == 5'h00)
		else $error("level set in shutdown");
	AST_HOT_ZERO: assert property (
		thermal_off |-> primary_led_channels == 5'h00)
		else $error("output on while hot");
	AST_HOT_TRIP: assert property (
		$rose(over_temp) |-> ##[1:6] thermal_off)
		else $error("no thermal trip");
	AST_OFF_TIME: assert property (
		low_cnt > OFF_CYCLES + 8 |-> !enabled)
		else $error("no shutdown");
	AST_EN_ZERO: assert property (
		$rose(enabled) |-> secondary_led_channels == 5'h00)
		else $error("level not zero on enable");
endmodule // pcd_checker

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import pcd_pkg::*;
	localparam int OFF = 200;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_enable = 1'b0;
	logic cmd_shutdown = 1'b0;
	pcd_group_type cmd_pulse = 2'h0;
	logic single_wire = 1'b0;
	logic over_temp = 1'b0;
	logic temp_cooled = 1'b0;
	logic busy, enabled, thermal_off;
	pcd_level_type lm, ls, lm2, ls2;
	int errors = 0;
	int n_tests = 0;
	pcd_link_if link();
	pcd_link_if link2();
	pcd_host #(.OFF_CYCLES(OFF), .SETUP_CYCLES(20)) pcd_host_inst (.sys_clk(sys_clk),
		.resetn(resetn), .cmd_enable(cmd_enable), .cmd_shutdown(cmd_shutdown),
		.cmd_pulse(cmd_pulse), .single_wire(single_wire), .busy(busy), .link(link));
	pcd_device #(.OFF_CYCLES(OFF)) pcd_device_inst (.sys_clk(sys_clk), .resetn(resetn),
		.link(link), .over_temp(over_temp), .temp_cooled(temp_cooled),
		.primary_led_channels(lm), .secondary_led_channels(ls), .enabled(enabled),
		.thermal_off(thermal_off));
	// Second device faces a driver that pulses while disabled
	pcd_device #(.OFF_CYCLES(OFF)) pcd_device_inst2 (.sys_clk(sys_clk), .resetn(resetn),
		.link(link2), .over_temp(1'b0), .temp_cooled(1'b0), .primary_led_channels(lm2),
		.secondary_led_channels(ls2), .enabled(), .thermal_off());
	pcd_checker #(.OFF_CYCLES(OFF)) pcd_checker_inst (.sys_clk(sys_clk), .resetn(resetn),
		.chip_on(link.chip_on), .main_group_pulse_n(link.main_group_pulse_n),
		.sub_group_pulse_n(link.sub_group_pulse_n), .over_temp(over_temp),
		.primary_led_channels(lm), .secondary_led_channels(ls), .enabled(enabled),
		.thermal_off(thermal_off));
	////////////////////////////////////////
	task automatic cmp_lvl(pcd_level_type e, pcd_level_type g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("Error %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_bit(logic e, logic g);
		cmp_lvl({4'h0, e}, {4'h0, g});
	endtask
	task automatic cmd(logic en, logic sd, pcd_group_type p);
		@(negedge sys_clk);
		{cmd_enable, cmd_shutdown, cmd_pulse} = {en, sd, p};
		@(negedge sys_clk);
		{cmd_enable, cmd_shutdown, cmd_pulse} = 4'h0;
		cmp_bit(1'b1, busy);
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			@(negedge sys_clk);
		cmp_bit(1'b0, busy);
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic t_count();
		cmd(1'b1, 1'b0, 2'h0);
		cmp_lvl(5'h00, lm);
		for (int i = 0; i < 33; i++) begin
			cmd(1'b0, 1'b0, 2'h1);
			cmp_lvl(5'h1F - 5'(i), lm);
		end
		cmp_lvl(5'h00, ls);
		cmd(1'b0, 1'b0, 2'h3);
		cmp_lvl(5'h1E, lm);
		cmp_lvl(5'h1F, ls);
	endtask
	task automatic t_hot();
		over_temp = 1'b1;
		repeat (8) @(negedge sys_clk);
		cmp_bit(1'b1, thermal_off);
		cmp_lvl(5'h00, lm);
		{over_temp, temp_cooled} = 2'b01;
		repeat (8) @(negedge sys_clk);
		cmp_bit(1'b0, thermal_off);
		cmp_lvl(5'h1E, lm);
		temp_cooled = 1'b0;
	endtask
	task automatic t_shut();
		cmd(1'b0, 1'b1, 2'h0);
		repeat (OFF + 20) @(negedge sys_clk);
		cmp_bit(1'b0, enabled);
		cmp_lvl(5'h00, ls);
	endtask
	task automatic t_single();
		single_wire = 1'b1;
		cmd(1'b1, 1'b0, 2'h0);
		cmd(1'b0, 1'b0, 2'h1);
		cmp_lvl(5'h1F, ls);
		cmd(1'b0, 1'b0, 2'h1);
		cmp_lvl(5'h1E, lm);
		cmp_bit(1'b1, enabled);
		t_shut();
		single_wire = 1'b0;
	endtask
	task automatic wire2(logic on, logic pn);
		@(negedge sys_clk);
		{link2.chip_on, link2.main_group_pulse_n, link2.sub_group_pulse_n} = {on, pn, pn};
		repeat (40) @(negedge sys_clk);
	endtask
	task automatic t_ignore();
		wire2(1'b0, 1'b0);
		wire2(1'b0, 1'b1);
		cmp_lvl(5'h00, lm2);
		wire2(1'b1, 1'b1);
		wire2(1'b1, 1'b0);
		wire2(1'b0, 1'b1);
		wire2(1'b0, 1'b0);
		wire2(1'b1, 1'b1);
		cmp_lvl(5'h1F, ls2);
	endtask
	task automatic close_out();
		$display("Checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial forever #4 sys_clk = ~sys_clk;
	initial begin
		{link2.chip_on, link2.main_group_pulse_n, link2.sub_group_pulse_n} = 3'b011;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1'b1;
		t_count();
		t_hot();
		t_shut();
		t_single();
		t_ignore();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		close_out();
	end
endmodule // tb_top
